// *** logic/ebm_pkg.sv ***
// Package for the energy optimizer, fuel gauge and capacitor balance block
package ebm_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned BAL_PERIOD_US = 1000;
   localparam int unsigned BAL_PERIOD_CYCLES = (CLK_HZ / 1000000) * BAL_PERIOD_US;
   localparam int VOLT_W = 5;
   localparam int LEVEL_W = 5;
   localparam int COUNT_W = 32;
   localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h0b;
   localparam logic [LEVEL_W-1:0] LEVEL_MAX = 5'h1f;
   localparam logic [LEVEL_W-1:0] LEVEL_MIN = 5'h00;
   localparam logic [VOLT_W-1:0] SEVERE_DEFICIT = 5'h03;
   localparam logic [VOLT_W-1:0] SURPLUS_LIMIT = 5'h01;
   localparam logic [VOLT_W-1:0] BAL_MIN_VCAP = 5'h0a;
   localparam logic [VOLT_W-1:0] BAL_WINDOW = 5'h01;
   localparam logic [VOLT_W-1:0] BAL_HYST = 5'h01;
   localparam logic [2:0] ST_CONT_ACTIVE = 3'h6;
   localparam logic [2:0] ST_CONT_CHARGE = 3'h2;
   localparam logic [2:0] ST_DEM_ACTIVE = 3'h5;
   localparam logic [2:0] ST_DEM_CHARGE = 3'h1;
   localparam logic [15:0] BAL_TICK_MAX = 16'(BAL_PERIOD_CYCLES - 1);

   typedef enum logic [1:0] {EBM_BAL_OFF, EBM_BAL_SOURCE, EBM_BAL_SINK} ebm_bal_dir_type;

   typedef struct packed {
      logic [1:0] current_sel;
      logic source_on;
      logic sink_on;
   } ebm_bal_drive_type;

   typedef struct packed {
      logic [LEVEL_W-1:0] target_charge_level;
      logic optimized;
   } ebm_opt_out_type;

   // Decision of the optimizer from end-of-cycle margin comparison
   function automatic logic [1:0] ebm_step_up(input logic [VOLT_W-1:0] vcap,
                                              input logic [VOLT_W-1:0] margin);
      logic [1:0] step;
      step = 2'h0;
      if (vcap < margin) begin
         if ((margin - vcap) >= SEVERE_DEFICIT) begin
            step = 2'h2;
         end else begin
            step = 2'h1;
         end
      end
      return step;
   endfunction
endpackage

// *** logic/ebm_fuel_gauge.sv ***
// Fuel gauge counter of boost conversion cycles
`timescale 1ns/1ns
module ebm_fuel_gauge
   import ebm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic count_pulse,
   input wire logic clear,
   output logic [COUNT_W-1:0] count
);
   typedef struct packed {
      logic [COUNT_W-1:0] count;
   } ebm_fg_state_type;

   ebm_fg_state_type state;
   ebm_fg_state_type next_state;

   always_comb begin
      next_state = state;
      if (clear) begin
         // Clear of the last cycle's count loses a coincident pulse, which belongs to the new cycle
         next_state.count = '0;
      end else if (count_pulse) begin
         next_state.count = state.count + 32'h00000001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign count = state.count;
endmodule

// *** logic/ebm_balance.sv ***
// Capacitor balance controller sampling the mid-point every millisecond
`timescale 1ns/1ns
module ebm_balance
   import ebm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic charging,
   input wire logic bal_enable,
   input wire logic [1:0] bal_current_sel,
   input wire logic [VOLT_W-1:0] storage_cap_voltage,
   input wire logic [VOLT_W-1:0] mid_voltage,
   output ebm_bal_drive_type drive
);
   typedef struct packed {
      logic [15:0] tick;
      ebm_bal_dir_type dir;
      ebm_bal_drive_type drive;
   } ebm_bal_state_type;

   ebm_bal_state_type state;
   ebm_bal_state_type next_state;

   always_comb begin
      logic [VOLT_W:0] half;
      logic [VOLT_W:0] mid2;
      logic [VOLT_W:0] band;
      half = {1'b0, storage_cap_voltage};
      mid2 = {mid_voltage, 1'b0};
      next_state = state;
      // Window narrows while a direction is held, so a held drive runs on to balance without chatter
      band = (state.dir == EBM_BAL_OFF) ? {1'b0, BAL_WINDOW} : {1'b0, BAL_WINDOW - BAL_HYST};
      if (!bal_enable || storage_cap_voltage < BAL_MIN_VCAP) begin
         next_state.dir = EBM_BAL_OFF;
         next_state.tick = '0;
      end else if (charging) begin
         if (state.tick == BAL_TICK_MAX) begin
            next_state.tick = '0;
            case (state.dir)
               EBM_BAL_OFF, EBM_BAL_SOURCE, EBM_BAL_SINK: begin
                  if (mid2 > half + band) begin
                     next_state.dir = EBM_BAL_SINK;
                  end else if (mid2 + band < half) begin
                     next_state.dir = EBM_BAL_SOURCE;
                  end else begin
                     next_state.dir = EBM_BAL_OFF;
                  end
               end
               default: begin
                  next_state.dir = EBM_BAL_OFF;
               end
            endcase
         end else begin
            next_state.tick = state.tick + 16'h0001;
         end
      end else begin
         next_state.dir = EBM_BAL_OFF;
         next_state.tick = '0;
      end
      next_state.drive.current_sel = bal_current_sel;
      next_state.drive.source_on = (next_state.dir == EBM_BAL_SOURCE);
      next_state.drive.sink_on = (next_state.dir == EBM_BAL_SINK);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= '{tick: '0, dir: EBM_BAL_OFF, drive: '0};
      end else begin
         state <= next_state;
      end
   end

   assign drive = state.drive;
endmodule

// *** logic/ebm_energy_manager.sv ***
// Energy manager top: adaptive optimizer, fuel gauge and capacitor balance
`timescale 1ns/1ns
module ebm_energy_manager
   import ebm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [2:0] state_code,
   input wire logic standby,
   input wire logic cycle_end,
   input wire logic [VOLT_W-1:0] storage_cap_voltage,
   input wire logic [VOLT_W-1:0] margin_voltage,
   input wire logic boost_cycle,
   input wire logic charging,
   input wire logic bal_enable,
   input wire logic [1:0] bal_current_sel,
   input wire logic [VOLT_W-1:0] mid_voltage,
   output ebm_opt_out_type opt_out,
   output logic [COUNT_W-1:0] fuel_count,
   output logic fuel_count_valid,
   output ebm_bal_drive_type bal_drive
);
   typedef enum logic [1:0] {EBM_OPT_LEARN, EBM_OPT_DONE} ebm_opt_phase_type;

   typedef struct packed {
      logic [2:0] prev_code;
      ebm_opt_phase_type phase;
      ebm_opt_out_type opt;
      logic [COUNT_W-1:0] fuel_count;
      logic fuel_count_valid;
   } ebm_top_state_type;

   ebm_top_state_type state;
   ebm_top_state_type next_state;
   logic fg_clear;
   logic [COUNT_W-1:0] fg_count;

   ////////////////////////////////////////////////////////////////////////////////
   // Fuel gauge

   // Clear on the active-to-charge move of either operating mode
   assign fg_clear = (state.prev_code == ST_CONT_ACTIVE && state_code == ST_CONT_CHARGE)
      || (state.prev_code == ST_DEM_ACTIVE && state_code == ST_DEM_CHARGE);

   ebm_fuel_gauge u_fuel_gauge (
      .clk_sys(clk_sys),
      .reset(reset),
      .count_pulse(boost_cycle & charging),
      .clear(fg_clear),
      .count(fg_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Capacitor balance

   ebm_balance u_balance (
      .clk_sys(clk_sys),
      .reset(reset),
      .charging(charging),
      .bal_enable(bal_enable),
      .bal_current_sel(bal_current_sel),
      .storage_cap_voltage(storage_cap_voltage),
      .mid_voltage(mid_voltage),
      .drive(bal_drive)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Optimizer

   always_comb begin
      logic [1:0] step;
      logic [LEVEL_W:0] raised;
      step = ebm_step_up(storage_cap_voltage, margin_voltage);
      raised = {1'b0, state.opt.target_charge_level} + {4'h0, step};
      next_state = state;
      next_state.prev_code = state_code;
      if (cycle_end) begin
         case (state.phase)
            EBM_OPT_LEARN, EBM_OPT_DONE: begin
               if (step != 2'h0) begin
                  // Saturate at the top level instead of wrapping
                  next_state.opt.target_charge_level = raised[LEVEL_W] ? LEVEL_MAX
                     : raised[LEVEL_W-1:0];
                  next_state.phase = EBM_OPT_LEARN;
               // One spare bit so a margin near full scale cannot wrap the surplus test
               end else if ({1'b0, storage_cap_voltage} > ({1'b0, margin_voltage} + {1'b0, SURPLUS_LIMIT})) begin
                  if (state.opt.target_charge_level != LEVEL_MIN) begin
                     next_state.opt.target_charge_level = state.opt.target_charge_level - 5'h01;
                  end
                  next_state.phase = EBM_OPT_LEARN;
               end else begin
                  next_state.phase = EBM_OPT_DONE;
               end
            end
            default: begin
               next_state.phase = EBM_OPT_LEARN;
            end
         endcase
      end
      next_state.opt.optimized = (next_state.phase == EBM_OPT_DONE);
      // Snapshot offered to the host only while in standby
      next_state.fuel_count_valid = standby;
      if (standby) begin
         next_state.fuel_count = fg_count;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= '{prev_code: '0, phase: EBM_OPT_LEARN, opt: '{target_charge_level: LEVEL_RESET, optimized: 1'b0},
                    fuel_count: '0, fuel_count_valid: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign opt_out = state.opt;
   assign fuel_count = state.fuel_count;
   assign fuel_count_valid = state.fuel_count_valid;
endmodule

// *** dv/ebm_props.sv ***
// Port-level assertions for the energy manager
`timescale 1ns/1ns
module ebm_props
   import ebm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [2:0] state_code,
   input wire logic standby,
   input wire logic cycle_end,
   input wire logic [VOLT_W-1:0] storage_cap_voltage,
   input wire logic [VOLT_W-1:0] margin_voltage,
   input wire logic boost_cycle,
   input wire logic charging,
   input wire logic bal_enable,
   input wire logic [1:0] bal_current_sel,
   input wire logic [VOLT_W-1:0] mid_voltage,
   input wire ebm_opt_out_type opt_out,
   input wire logic [COUNT_W-1:0] fuel_count,
   input wire logic fuel_count_valid,
   input wire ebm_bal_drive_type bal_drive
);
default clocking @(posedge clk_sys); endclocking
default disable iff (reset);
wire logic [4:0] lvl = opt_out.target_charge_level;
wire logic [4:0] vc = storage_cap_voltage;
wire logic [4:0] mg = margin_voltage;
wire logic [4:0] dft = mg - vc;
wire logic clr = (state_code == ST_CONT_CHARGE) || (state_code == ST_DEM_CHARGE);
////////////////////////////////////////////////////////////////////////////////
a_severe_two_step: assert property (cycle_end && vc < mg && dft >= 5'h03 && lvl < 5'h1e
   |=> lvl == $past(lvl) + 5'h02 && !opt_out.optimized) else $error("level did not rise by two");
a_mild_one_step: assert property (cycle_end && vc < mg && dft < 5'h03 && lvl != 5'h1f
   |=> lvl == $past(lvl) + 5'h01) else $error("level did not rise by one");
a_margin_hold: assert property (cycle_end && vc >= mg && vc - mg <= 5'h01
   |=> $stable(lvl) && opt_out.optimized) else $error("level moved at margin");
a_surplus_down: assert property (cycle_end && vc > mg && vc - mg > 5'h01 && lvl != 5'h00
   |=> lvl == $past(lvl) - 5'h01) else $error("level did not step down");
a_level_idle: assert property (!cycle_end |=> $stable(lvl)) else $error("level moved without cycle end");
a_fuel_clear: assert property (clr && $past(state_code) - state_code == 3'h4 ##1 standby
   |=> fuel_count == 32'h0) else $error("count not cleared");
a_valid_follow: assert property (standby |=> fuel_count_valid) else $error("valid missing in standby");
a_count_hold: assert property (!standby |=> $stable(fuel_count)) else $error("count moved outside standby");
a_bal_gated: assert property (!bal_enable || !charging || vc < BAL_MIN_VCAP
   |=> !bal_drive.source_on && !bal_drive.sink_on) else $error("balance drive while gated");
a_bal_exclusive: assert property (!(bal_drive.source_on && bal_drive.sink_on)) else $error("source and sink");
a_bal_current: assert property (1 |=> bal_drive.current_sel == $past(bal_current_sel))
   else $error("current select lag wrong");
c_severe: cover property (cycle_end && vc < mg && dft >= 5'h03);
c_sink: cover property (bal_drive.sink_on);
c_count: cover property (fuel_count_valid && fuel_count != 32'h0);
endmodule
bind ebm_energy_manager ebm_props u_props (.clk_sys, .reset, .state_code, .standby, .cycle_end,
   .storage_cap_voltage, .margin_voltage, .boost_cycle, .charging, .bal_enable, .bal_current_sel,
   .mid_voltage, .opt_out, .fuel_count, .fuel_count_valid, .bal_drive);

// *** dv/ebm_host_model.sv ***
// Host model that reads the fuel gauge on standby entry and keeps a total
`timescale 1ns/1ns
module ebm_host_model
   import ebm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic fuel_count_valid,
   input wire logic [COUNT_W-1:0] fuel_count,
   output logic [63:0] total
);
logic seen;
// The device clears each cycle, so only the running sum tells battery use
always_ff @(posedge clk_sys) begin
   seen <= fuel_count_valid;
   if (reset) total <= 64'h0;
   else if (fuel_count_valid && !seen) total <= total + 64'(fuel_count);
end
endmodule

// *** dv/ebm_energy_manager_tb.sv ***
// Self-checking bench for the energy manager
`timescale 1ns/1ns
module ebm_energy_manager_tb
   import ebm_pkg::*;
;
logic clk_sys = 0, reset = 1, standby = 0, cycle_end = 0, boost_cycle = 0, charging = 0, bal_enable = 0;
logic [2:0] state_code = 3'h0;
logic [4:0] storage_cap_voltage = 5'h00, margin_voltage = 5'h08, mid_voltage = 5'h00;
logic [1:0] bal_current_sel = 2'h0;
ebm_opt_out_type opt_out;
ebm_bal_drive_type bal_drive;
logic [31:0] fuel_count;
logic fuel_count_valid;
logic [63:0] total;
int error_cnt = 0, n_compared = 0, cyc = 0, n;
logic [4:0] ov [8] = '{5'h08, 5'h05, 5'h07, 5'h06, 5'h09, 5'h09, 5'h0b, 5'h07};
logic [4:0] ol [8] = '{5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h0f, 5'h0f, 5'h0e, 5'h0f};
ebm_energy_manager DUT (.clk_sys, .reset, .state_code, .standby, .cycle_end, .storage_cap_voltage,
   .margin_voltage, .boost_cycle, .charging, .bal_enable, .bal_current_sel, .mid_voltage, .opt_out,
   .fuel_count, .fuel_count_valid, .bal_drive);
ebm_host_model u_host (.clk_sys, .reset, .fuel_count_valid, .fuel_count, .total);
initial begin
   forever #25 clk_sys = ~clk_sys;
end
////////////////////////////////////////////////////////////////////////////////
task complete_run;
   $display("compared %0d mismatches %0d", n_compared, error_cnt);
   if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
   else $display("== FAILED ==");
   $finish;
endtask
task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
   n_compared++;
   if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
   end
endtask
task tick(input int k);
   repeat (k) @(posedge clk_sys);
   #5;
endtask
// Extra edge after the state change keeps the first pulse clear of the clear cycle
task fuel_round(input logic [2:0] act, input logic [2:0] chg, input int k);
   standby = 0; state_code = act; tick(1); state_code = chg; tick(2); charging = 1;
   repeat (k) begin
      boost_cycle = 1; tick(1); boost_cycle = 0; tick(1);
   end
   charging = 0; boost_cycle = 1; tick(1); boost_cycle = 0; standby = 1; tick(3);
   check("fuel count", fuel_count, 64'(k));
   check("count valid", fuel_count_valid, 1'b1);
endtask
// Bounded wait for one drive direction; bounded just past one sample period
task wait_on(input logic sink);
   n = 0;
   while ((sink ? bal_drive.sink_on : bal_drive.source_on) !== 1'b1 && n < 20100) begin
      tick(1); n++;
   end
endtask
always @(posedge clk_sys) begin
   cyc <= cyc + 1;
   if (cyc == 100000) begin
      error_cnt++; complete_run();
   end
end
initial begin
   tick(16); reset = 0; tick(1);
   check("reset level", opt_out, {5'h0b, 1'b0});
   check("reset fuel", {fuel_count_valid, fuel_count}, 64'h0);
   check("reset drive", bal_drive, 4'h0);
   for (int i = 0; i < 8; i++) begin
      storage_cap_voltage = ov[i]; cycle_end = 1; tick(1); cycle_end = 0; tick(1);
      check("level", opt_out.target_charge_level, ol[i]);
      if (i != 6) check("optimized", opt_out.optimized, 8'h31 >> i & 8'h01);
   end
   fuel_round(ST_CONT_ACTIVE, ST_CONT_CHARGE, 5);
   fuel_round(ST_DEM_ACTIVE, ST_DEM_CHARGE, 3);
   tick(1); check("host total", total, 64'h8);
   state_code = ST_CONT_ACTIVE; tick(1); state_code = ST_CONT_CHARGE; tick(3);
   check("standby clear", fuel_count, 64'h0);
   storage_cap_voltage = 5'h10; mid_voltage = 5'h0a; bal_current_sel = 2'h2; charging = 1; bal_enable = 1;
   wait_on(1); check("sink wait", n <= 20001, 1'b1);
   check("sink drive", bal_drive, {2'h2, 2'b01});
   mid_voltage = 5'h06; tick(100); check("held sink", bal_drive.sink_on, 1'b1);
   wait_on(0); check("source wait", n >= 19800 && n <= 20001, 1'b1);
   storage_cap_voltage = 5'h11; mid_voltage = 5'h08; tick(20010);
   check("hysteresis", bal_drive.source_on, 1'b1);
   bal_current_sel = 2'h1; tick(2); check("cur sel", bal_drive.current_sel, 2'h1);
   storage_cap_voltage = 5'h09; tick(2); check("low cap", bal_drive, {2'h1, 2'b00});
   storage_cap_voltage = 5'h11; bal_enable = 0; tick(2); check("disabled", bal_drive, {2'h1, 2'b00});
   complete_run();
end
endmodule
